// >>> sfc_params.svh
// What this block does
// - Host opens with chip select, one opcode
// - All bytes shift most significant bit first
// - Chip select release ends every command frame
// - Unknown opcode: ignore input until next frame
// - Truncated opcode or address: no operation
// - Top five address bits are dropped
// - Reads 0Bh with dummy, 03h without
// - 03h only to 25 MHz, 0Bh 70 MHz; the host holds every opcode, 0Bh included, to the 25 MHz slow-read limit
// - Erase opcodes except chip erase framed with address, no data
// - Page program 02h: address, 1-256 data bytes
// - Dual-input program A2h: address, data bytes
// - Sequential program: address first frame only
// - Protection opcodes framed per their byte counts
// - Secure area program and read framing
// - Status read, interrupt, write framing
// - Id read streams; reset needs D0h byte
// - Power-down opcodes carry no further bytes
// - Read address counter advances every byte
// - After header, each clock shifts data out
// - Read wraps from top to zero seamlessly
// - Chip select release stops read, floats output
// - Sample on rising, change on falling edge
// - Dual read: two bits per clock
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

// Array geometry
`define SFC_ARRAY_AW       19
`define SFC_ADDR_BYTES     2'h3
`define SFC_DUMMY_ONE      2'h1
`define SFC_DUMMY_TWO      2'h2
`define SFC_PAGE_BYTES     9'h100
`define SFC_RESET_CONFIRM  8'hd0

// Clock rates in MHz
`define SFC_CORE_MHZ            40
`define SFC_SLOW_READ_CLOCK_LIMIT 25
`define SFC_FAST_READ_MHZ       70
// Least half period of the serial clock in core cycles for the slow read
`define SFC_SLOW_HALF_MIN ((`SFC_CORE_MHZ + 2 * `SFC_SLOW_READ_CLOCK_LIMIT - 1) / (2 * `SFC_SLOW_READ_CLOCK_LIMIT))
// Default half period; must cover both three-flop synchronisers
`define SFC_SCK_HALF_DEF   16

// Opcodes
`define SFC_OP_READ_FAST   8'h0b
`define SFC_OP_READ_SLOW   8'h03
`define SFC_OP_READ_DUAL   8'h3b
`define SFC_OP_PAGE_ERASE  8'h81
`define SFC_OP_ERASE_4K    8'h20
`define SFC_OP_ERASE_32K   8'h52
`define SFC_OP_ERASE_64K   8'hd8
`define SFC_OP_CHIP_ERA_A  8'h60
`define SFC_OP_CHIP_ERA_B  8'hc7
`define SFC_OP_PROGRAM     8'h02
`define SFC_OP_PROG_DUAL   8'ha2
`define SFC_OP_SEQ_A       8'had
`define SFC_OP_SEQ_B       8'haf
`define SFC_OP_WR_ENABLE   8'h06
`define SFC_OP_WR_DISABLE  8'h04
`define SFC_OP_PROTECT     8'h36
`define SFC_OP_UNPROTECT   8'h39
`define SFC_OP_RD_PROTECT  8'h3c
`define SFC_OP_OTP_PROG    8'h9b
`define SFC_OP_OTP_READ    8'h77
`define SFC_OP_RD_STATUS   8'h05
`define SFC_OP_STAT_IRQ    8'h25
`define SFC_OP_WR_STAT1    8'h01
`define SFC_OP_WR_STAT2    8'h31
`define SFC_OP_SOFT_RESET  8'hf0
`define SFC_OP_READ_ID     8'h9f
`define SFC_OP_DEEP_PD     8'hb9
`define SFC_OP_RESUME_PD   8'hab
`define SFC_OP_ULTRA_PD    8'h79

`endif

// >>> sfc_pkg.sv
`default_nettype none
`include "sfc_params.svh"
package sfc_pkg;

  typedef enum logic [2:0] {SFC_K_NONE, SFC_K_DIN1, SFC_K_DINN, SFC_K_RD_ARRAY,
                            SFC_K_RD_AUX} sfc_kind_e;

  typedef struct packed {
    logic       ok;
    logic [1:0] n_addr;
    logic [1:0] n_dummy;
    sfc_kind_e  kind;
    logic       dual;
  } sfc_frame_s;

  typedef enum logic [2:0] {SFC_DS_OPC, SFC_DS_ADDR, SFC_DS_DUMMY, SFC_DS_DIN,
                            SFC_DS_READ, SFC_DS_DONE, SFC_DS_IGNORE} sfc_dev_state_e;

  typedef enum logic [2:0] {SFC_HS_IDLE, SFC_HS_SETUP, SFC_HS_LOAD, SFC_HS_XFER,
                            SFC_HS_END} sfc_host_state_e;

  typedef struct packed {
    sfc_dev_state_e           state;
    logic [2:0]               cs_s;
    logic [2:0]               sck_s;
    logic [2:0]               si_s;
    logic                     cs_q;
    logic                     sck_q;
    logic                     si_q;
    logic [2:0]               bitc;
    logic [1:0]               byc;
    logic [7:0]               in_sr;
    logic [7:0]               opcode;
    sfc_frame_s               fr;
    logic [23:0]              addr;
    logic [`SFC_ARRAY_AW-1:0] rd_addr;
    logic [2:0]               ocnt;
    logic [7:0]               out_sr;
    logic                     so;
    logic                     serial_in_dual_pin;
    logic                     so_oe;
    logic                     sio_oe;
    logic [8:0]               cnt;
    logic                     seq;
    logic [`SFC_ARRAY_AW-1:0] seq_addr;
    logic                     cmd_valid;
    logic [7:0]               c_op;
    logic [`SFC_ARRAY_AW-1:0] c_addr;
    logic [8:0]               c_cnt;
    logic                     data_valid;
    logic [7:0]               data;
  } sfc_dev_s;

  typedef struct packed {
    sfc_host_state_e state;
    logic            cs_n;
    logic            sck;
    logic            si;
    logic            si_oe;
    logic [7:0]      div;
    logic [3:0]      bitc;
    logic [7:0]      tx;
    logic [7:0]      rx;
    logic [7:0]      op;
    logic [23:0]     addr;
    logic [1:0]      n_addr;
    logic [1:0]      n_dummy;
    logic [8:0]      n_wr;
    logic [15:0]     n_rd;
    logic            opc_pend;
    logic            dual;
    logic            cur_rd;
    logic [2:0]      so_s;
    logic [2:0]      si_s;
    logic            so_q;
    logic            si_q;
    logic [1:0][7:0] bmem;
    logic            wp;
    logic            rp;
    logic [1:0]      bcnt;
  } sfc_host_s;

  // Pin filter: a change counts once the second and third stages agree
  function automatic logic sfc_filt(input logic s2, input logic s3, input logic q);
    return (s2 == s3) ? s3 : q;
  endfunction

  // Framing of every supported opcode
  function automatic sfc_frame_s sfc_decode(input logic [7:0] op, input logic seq);
    sfc_frame_s f;
    f = '{ok: 1'b1, n_addr: 2'h0, n_dummy: 2'h0, kind: SFC_K_NONE, dual: 1'b0};
    case (op)
      `SFC_OP_READ_FAST: f = '{1'b1, `SFC_ADDR_BYTES, `SFC_DUMMY_ONE, SFC_K_RD_ARRAY, 1'b0};
      `SFC_OP_READ_SLOW: f = '{1'b1, `SFC_ADDR_BYTES, 2'h0, SFC_K_RD_ARRAY, 1'b0};
      `SFC_OP_READ_DUAL: f = '{1'b1, `SFC_ADDR_BYTES, `SFC_DUMMY_ONE, SFC_K_RD_ARRAY, 1'b1};
      `SFC_OP_PAGE_ERASE, `SFC_OP_ERASE_4K, `SFC_OP_ERASE_32K, `SFC_OP_ERASE_64K,
      `SFC_OP_PROTECT, `SFC_OP_UNPROTECT: f.n_addr = `SFC_ADDR_BYTES;
      `SFC_OP_CHIP_ERA_A, `SFC_OP_CHIP_ERA_B, `SFC_OP_WR_ENABLE, `SFC_OP_WR_DISABLE,
      `SFC_OP_DEEP_PD, `SFC_OP_RESUME_PD, `SFC_OP_ULTRA_PD: f.kind = SFC_K_NONE;
      `SFC_OP_PROGRAM, `SFC_OP_PROG_DUAL, `SFC_OP_OTP_PROG:
        f = '{1'b1, `SFC_ADDR_BYTES, 2'h0, SFC_K_DINN, 1'b0};
      `SFC_OP_SEQ_A, `SFC_OP_SEQ_B:
        f = '{1'b1, seq ? 2'h0 : `SFC_ADDR_BYTES, 2'h0, SFC_K_DIN1, 1'b0};
      `SFC_OP_RD_PROTECT: f = '{1'b1, `SFC_ADDR_BYTES, 2'h0, SFC_K_RD_AUX, 1'b0};
      `SFC_OP_OTP_READ: f = '{1'b1, `SFC_ADDR_BYTES, `SFC_DUMMY_TWO, SFC_K_RD_AUX, 1'b0};
      `SFC_OP_RD_STATUS, `SFC_OP_READ_ID: f.kind = SFC_K_RD_AUX;
      `SFC_OP_STAT_IRQ: f.n_dummy = `SFC_DUMMY_ONE;
      `SFC_OP_WR_STAT1, `SFC_OP_WR_STAT2, `SFC_OP_SOFT_RESET: f.kind = SFC_K_DIN1;
      default: f.ok = 1'b0;
    endcase
    return f;
  endfunction

endpackage
`default_nettype wire

// >>> sfc_spi_if.sv
`timescale 1ns/100ps
`default_nettype none
// Four-wire link; the serial input pin turns round during the dual read
interface sfc_spi_if;
  logic cs_n;
  logic sck;
  logic si_h;
  logic si_h_oe;
  logic si_d;
  logic si_d_oe;
  logic so_d;
  logic so_d_oe;
  logic si;
  logic so;

  // Wire levels; an undriven pin reads high as if pulled up
  assign si = si_h_oe ? si_h : (si_d_oe ? si_d : 1'b1);
  assign so = so_d_oe ? so_d : 1'b1;

  modport host (output cs_n, sck, si_h, si_h_oe, input si, so);
  modport dev  (input cs_n, sck, si, output si_d, si_d_oe, so_d, so_d_oe);
endinterface
`default_nettype wire

// >>> sfc_dev_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfc_params.svh"
module sfc_dev_end
(
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  sfc_spi_if.dev                        spi,
  input  wire logic                     mem_wr_i,
  input  wire logic [`SFC_ARRAY_AW-1:0] mem_waddr_i,
  input  wire logic [7:0]               mem_wdata_i,
  input  wire logic [7:0]               aux_byte_i,
  output logic                          cmd_valid_o,
  output logic [7:0]                    cmd_opcode_o,
  output logic [`SFC_ARRAY_AW-1:0]      cmd_addr_o,
  output logic [8:0]                    cmd_count_o,
  output logic                          data_valid_o,
  output logic [7:0]                    data_o,
  output logic                          seq_mode_o
);
  localparam int AW = `SFC_ARRAY_AW;

  sfc_pkg::sfc_dev_s r;
  sfc_pkg::sfc_dev_s next_r;
  logic [7:0]        mem [0:(1<<AW)-1];
  logic [7:0]        mem_q;
  logic              rise;
  logic              fall;

  // Which phase follows opcode (stage 0), address (1) or dummy (2)
  function automatic sfc_pkg::sfc_dev_state_e dev_after(input sfc_pkg::sfc_frame_s f,
                                                        input logic [1:0] stage);
    if (stage == 2'h0 && f.n_addr != 2'h0)
      return sfc_pkg::SFC_DS_ADDR;
    if (stage != 2'h2 && f.n_dummy != 2'h0)
      return sfc_pkg::SFC_DS_DUMMY;
    case (f.kind)
      sfc_pkg::SFC_K_DIN1, sfc_pkg::SFC_K_DINN: return sfc_pkg::SFC_DS_DIN;
      sfc_pkg::SFC_K_RD_ARRAY, sfc_pkg::SFC_K_RD_AUX: return sfc_pkg::SFC_DS_READ;
      default: return sfc_pkg::SFC_DS_DONE;
    endcase
  endfunction

  // A frame counts only once its header is in and, in the data phase, a whole data byte
  function automatic logic dev_complete(input sfc_pkg::sfc_dev_s s);
    case (s.state)
      sfc_pkg::SFC_DS_DONE, sfc_pkg::SFC_DS_READ: return 1'b1;
      sfc_pkg::SFC_DS_DIN: return (s.cnt != 9'h0) && (s.bitc == 3'h0);
      default: return 1'b0;
    endcase
  endfunction

  // Backing array; the user side loads it, the read path only reads it
  always_ff @(posedge core_clk_i)
  begin
    if (mem_wr_i)
      mem[mem_waddr_i] <= mem_wdata_i;
  end
  assign mem_q = mem[r.rd_addr];

  // Frame decode and shift engine
  always_comb
  begin
    logic [7:0]            b;
    sfc_pkg::sfc_frame_s   f;
    sfc_pkg::sfc_dev_state_e st;
    b  = {r.in_sr[6:0], r.si_q};
    f  = sfc_pkg::sfc_decode(b, r.seq);
    st = r.state;
    next_r = r;
    next_r.cs_s  = {r.cs_s[1:0], spi.cs_n};
    next_r.sck_s = {r.sck_s[1:0], spi.sck};
    next_r.si_s  = {r.si_s[1:0], spi.si};
    next_r.cs_q  = sfc_pkg::sfc_filt(r.cs_s[1], r.cs_s[2], r.cs_q);
    next_r.sck_q = sfc_pkg::sfc_filt(r.sck_s[1], r.sck_s[2], r.sck_q);
    next_r.si_q  = sfc_pkg::sfc_filt(r.si_s[1], r.si_s[2], r.si_q);
    rise = next_r.sck_q & ~r.sck_q;
    fall = ~next_r.sck_q & r.sck_q;
    next_r.cmd_valid  = 1'b0;
    next_r.data_valid = 1'b0;
    if (next_r.cs_q)
    begin
      // Release of chip select closes the frame; short frames just vanish
      if (!r.cs_q && dev_complete(r))
      begin
        next_r.cmd_valid = 1'b1;
        next_r.c_op      = r.opcode;
        next_r.c_cnt     = r.cnt;
        next_r.c_addr    = (r.fr.n_addr == 2'h0 && r.seq) ? r.seq_addr : r.addr[AW-1:0];
        next_r.seq       = (r.opcode == `SFC_OP_SEQ_A) || (r.opcode == `SFC_OP_SEQ_B);
        next_r.seq_addr  = next_r.c_addr + AW'(1);
      end
      next_r.state  = sfc_pkg::SFC_DS_OPC;
      next_r.bitc   = 3'h0;
      next_r.byc    = 2'h0;
      next_r.in_sr  = 8'h00;
      next_r.addr   = 24'h000000;
      next_r.cnt    = 9'h000;
      next_r.ocnt   = 3'h0;
      next_r.so_oe  = 1'b0;
      next_r.sio_oe = 1'b0;
    end
    else if (rise)
    begin
      next_r.in_sr = b;
      next_r.bitc  = r.bitc + 3'h1;
      if (r.bitc == 3'h7)
      begin
        case (r.state)
          sfc_pkg::SFC_DS_OPC:
          begin
            next_r.opcode = b;
            next_r.fr     = f;
            st = f.ok ? dev_after(f, 2'h0) : sfc_pkg::SFC_DS_IGNORE;
            next_r.byc = (st == sfc_pkg::SFC_DS_ADDR) ? f.n_addr - 2'h1 : f.n_dummy - 2'h1;
          end
          sfc_pkg::SFC_DS_ADDR:
          begin
            next_r.addr = {r.addr[15:0], b};
            next_r.byc  = (r.byc == 2'h0) ? r.fr.n_dummy - 2'h1 : r.byc - 2'h1;
            if (r.byc == 2'h0)
              st = dev_after(r.fr, 2'h1);
          end
          sfc_pkg::SFC_DS_DUMMY:
          begin
            next_r.byc = r.byc - 2'h1;
            if (r.byc == 2'h0)
              st = dev_after(r.fr, 2'h2);
          end
          sfc_pkg::SFC_DS_DIN:
          begin
            // Count saturates at one page; a page takes the last bytes sent
            next_r.data_valid = 1'b1;
            next_r.data       = b;
            if (r.cnt != `SFC_PAGE_BYTES)
              next_r.cnt = r.cnt + 9'h001;
            if (r.fr.kind == sfc_pkg::SFC_K_DIN1)
              st = (r.opcode == `SFC_OP_SOFT_RESET && b != `SFC_RESET_CONFIRM) ?
                   sfc_pkg::SFC_DS_IGNORE : sfc_pkg::SFC_DS_DONE;
          end
          default: st = r.state;
        endcase
      end
      next_r.state = st;
      if (st == sfc_pkg::SFC_DS_READ && r.state != sfc_pkg::SFC_DS_READ)
      begin
        next_r.rd_addr = next_r.addr[AW-1:0];
        next_r.ocnt    = 3'h0;
      end
    end
    else if (fall && r.state == sfc_pkg::SFC_DS_READ)
    begin
      // A new byte is fetched on the first falling edge of each byte slot
      if (r.ocnt == 3'h0)
      begin
        b = (r.fr.kind == sfc_pkg::SFC_K_RD_ARRAY) ? mem_q : aux_byte_i;
        next_r.rd_addr = r.rd_addr + AW'(1);
      end
      else
        b = r.out_sr;
      next_r.so     = b[7];
      next_r.serial_in_dual_pin    = b[6];
      next_r.so_oe  = 1'b1;
      next_r.sio_oe = r.fr.dual;
      next_r.out_sr = r.fr.dual ? {b[5:0], 2'h0} : {b[6:0], 1'b0};
      next_r.ocnt   = r.ocnt + (r.fr.dual ? 3'h2 : 3'h1);
    end
  end

  // State register; chip select starts out released
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      r       <= '0;
      r.cs_s  <= 3'h7;
      r.cs_q  <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign spi.so_d    = r.so;
  assign spi.so_d_oe = r.so_oe;
  assign spi.si_d    = r.serial_in_dual_pin;
  assign spi.si_d_oe = r.sio_oe;
  assign cmd_valid_o  = r.cmd_valid;
  assign cmd_opcode_o = r.c_op;
  assign cmd_addr_o   = r.c_addr;
  assign cmd_count_o  = r.c_cnt;
  assign data_valid_o = r.data_valid;
  assign data_o       = r.data;
  assign seq_mode_o   = r.seq;
endmodule
`default_nettype wire

// >>> sfc_host_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfc_params.svh"
module sfc_host_end #(
  parameter int SCK_HALF = `SFC_SCK_HALF_DEF
)
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  sfc_spi_if.host          spi,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [7:0]  cmd_opcode_i,
  input  wire logic [23:0] cmd_addr_i,
  input  wire logic [1:0]  cmd_n_addr_i,
  input  wire logic [1:0]  cmd_n_dummy_i,
  input  wire logic [8:0]  cmd_n_wr_i,
  input  wire logic [15:0] cmd_n_rd_i,
  input  wire logic        cmd_dual_i,
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  input  wire logic [7:0]  wr_data_i,
  output logic             rd_valid_o,
  input  wire logic        rd_ready_i,
  output logic [7:0]       rd_data_o,
  output logic             busy_o
);
  // Never run the clock faster than the slow read allows
  localparam int HALF = (SCK_HALF < `SFC_SLOW_HALF_MIN) ? `SFC_SLOW_HALF_MIN : SCK_HALF;
  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

  sfc_pkg::sfc_host_s r;
  sfc_pkg::sfc_host_s next_r;
  logic               tick;
  logic               push;
  logic               pop;

  assign cmd_ready_o = (r.state == sfc_pkg::SFC_HS_IDLE);
  assign busy_o      = ~cmd_ready_o;
  assign wr_ready_o  = (r.state == sfc_pkg::SFC_HS_LOAD) && !r.opc_pend &&
                       r.n_addr == 2'h0 && r.n_dummy == 2'h0 && r.n_wr != 9'h000;
  assign rd_valid_o  = (r.bcnt != 2'h0);
  assign rd_data_o   = r.bmem[r.rp];
  assign pop         = rd_valid_o & rd_ready_i;
  assign tick        = (r.div == HALF_M1);

  // Byte sequencer, clock divider and receive buffer
  always_comb
  begin
    logic [7:0] b;
    logic       load;
    logic       rdb;
    b    = 8'h00;
    load = 1'b0;
    rdb  = 1'b0;
    push = 1'b0;
    next_r = r;
    next_r.so_s = {r.so_s[1:0], spi.so};
    next_r.si_s = {r.si_s[1:0], spi.si};
    next_r.so_q = sfc_pkg::sfc_filt(r.so_s[1], r.so_s[2], r.so_q);
    next_r.si_q = sfc_pkg::sfc_filt(r.si_s[1], r.si_s[2], r.si_q);
    next_r.div  = tick ? 8'h00 : r.div + 8'h01;
    case (r.state)
      sfc_pkg::SFC_HS_IDLE:
      begin
        next_r.div = 8'h00;
        if (cmd_valid_i)
        begin
          next_r.cs_n     = 1'b0;
          next_r.op       = cmd_opcode_i;
          next_r.addr     = cmd_addr_i;
          next_r.n_addr   = cmd_n_addr_i;
          next_r.n_dummy  = cmd_n_dummy_i;
          next_r.n_wr     = cmd_n_wr_i;
          next_r.n_rd     = cmd_n_rd_i;
          next_r.dual     = cmd_dual_i;
          next_r.opc_pend = 1'b1;
          next_r.state    = sfc_pkg::SFC_HS_SETUP;
        end
      end
      sfc_pkg::SFC_HS_SETUP:
        if (tick)
          next_r.state = sfc_pkg::SFC_HS_LOAD;
      sfc_pkg::SFC_HS_LOAD:
      begin
        // Stalls with the clock low while write data or buffer room is missing
        next_r.div = 8'h00;
        if (r.opc_pend)
        begin
          b = r.op;
          next_r.opc_pend = 1'b0;
          load = 1'b1;
        end
        else if (r.n_addr != 2'h0)
        begin
          b = r.addr[23:16];
          next_r.addr   = {r.addr[15:0], 8'h00};
          next_r.n_addr = r.n_addr - 2'h1;
          load = 1'b1;
        end
        else if (r.n_dummy != 2'h0)
        begin
          next_r.n_dummy = r.n_dummy - 2'h1;
          load = 1'b1;
        end
        else if (r.n_wr != 9'h000)
        begin
          if (wr_valid_i)
          begin
            b = wr_data_i;
            next_r.n_wr = r.n_wr - 9'h001;
            load = 1'b1;
          end
        end
        else if (r.n_rd != 16'h0000)
        begin
          if (r.bcnt != 2'h2)
          begin
            rdb = 1'b1;
            next_r.n_rd = r.n_rd - 16'h0001;
            load = 1'b1;
          end
        end
        else
        begin
          next_r.cs_n  = 1'b1;
          next_r.si_oe = 1'b0;
          next_r.state = sfc_pkg::SFC_HS_END;
        end
        if (load)
        begin
          next_r.si     = b[7];
          next_r.tx     = {b[6:0], 1'b0};
          next_r.bitc   = 4'h0;
          next_r.cur_rd = rdb;
          next_r.si_oe  = !(rdb && r.dual);
          next_r.state  = sfc_pkg::SFC_HS_XFER;
        end
      end
      sfc_pkg::SFC_HS_XFER:
        if (tick)
        begin
          if (!r.sck)
          begin
            // Rising edge: sample what the device set up on the fall before
            next_r.sck  = 1'b1;
            next_r.rx   = (r.cur_rd && r.dual) ? {r.rx[5:0], r.so_q, r.si_q} :
                                                 {r.rx[6:0], r.so_q};
            next_r.bitc = r.bitc + ((r.cur_rd && r.dual) ? 4'h2 : 4'h1);
          end
          else
          begin
            next_r.sck = 1'b0;
            if (r.bitc == 4'h8)
            begin
              push = r.cur_rd;
              next_r.state = sfc_pkg::SFC_HS_LOAD;
            end
            else
            begin
              next_r.si = r.tx[7];
              next_r.tx = {r.tx[6:0], 1'b0};
            end
          end
        end
      sfc_pkg::SFC_HS_END:
        if (tick)
          next_r.state = sfc_pkg::SFC_HS_IDLE;
      default: next_r.state = sfc_pkg::SFC_HS_IDLE;
    endcase
    // Two-entry buffer; room is checked before a read byte is clocked
    if (push)
    begin
      next_r.bmem[r.wp] = r.rx;
      next_r.wp = ~r.wp;
    end
    if (pop)
      next_r.rp = ~r.rp;
    next_r.bcnt = r.bcnt + {1'b0, push} - {1'b0, pop};
  end

  // State register; chip select released and clock low after reset
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      r      <= '0;
      r.cs_n <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign spi.cs_n    = r.cs_n;
  assign spi.sck     = r.sck;
  assign spi.si_h    = r.si;
  assign spi.si_h_oe = r.si_oe;
endmodule
`default_nettype wire

// >>> sfc_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module sfc_link_assertions
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic so,
  input  wire logic si_h_oe,
  input  wire logic si_d_oe,
  input  wire logic so_d_oe
);
  logic [3:0] hi_cnt;
  logic [3:0] next_hi_cnt;

  // Cycles since chip select went high; saturates so long idles stay cheap
  always_comb next_hi_cnt = !cs_n ? 4'h0 : ((hi_cnt == 4'hf) ? hi_cnt : hi_cnt + 4'h1);
  always_ff @(posedge core_clk_i) hi_cnt <= rst_i ? 4'hf : next_hi_cnt;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Device must float both pins well before the next frame can open
  a_idle_so_float:  assert property (hi_cnt >= 4'h8 |-> !so_d_oe) else $error("so driven idle");
  a_idle_sio_float: assert property (hi_cnt >= 4'h8 |-> !si_d_oe) else $error("sio driven idle");
  a_idle_sck_low:   assert property (cs_n && $past(cs_n) |-> !sck) else $error("sck not idle low");
  a_select_setup:   assert property ($fell(cs_n) |-> !sck [*8]) else $error("sck rose too early");
  a_no_early_out:   assert property ($fell(cs_n) |-> !so_d_oe [*8]) else $error("so early");
  a_no_contention:  assert property (!(si_h_oe && si_d_oe)) else $error("si driven twice");
  a_so_hold_high:   assert property (sck && $past(sck) && so_d_oe && $past(so_d_oe) |-> $stable(so))
    else $error("so moved while sck high");
  a_si_hold_high:   assert property (sck && $past(sck) && si_h_oe && $past(si_h_oe) |-> $stable(si))
    else $error("si moved while sck high");

  c_read_out:  cover property ($rose(so_d_oe));
  c_open:      cover property ($fell(cs_n));
  c_close:     cover property ($rose(cs_n) && !sck);
  c_dual_out:  cover property ($rose(si_d_oe));
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfc_params.svh"
module tb_top;
  logic                     core_clk_i = 1'b0, rst_i = 1'b1;
  logic                     cmd_valid_i = 1'b0, wr_valid_i = 1'b0, rd_ready_i = 1'b0;
  logic [7:0]               cmd_opcode_i = 8'h00, wr_data_i = 8'h00, aux = 8'h4e;
  logic [23:0]              cmd_addr_i = 24'h000000;
  logic [1:0]               n_addr = 2'h0, n_dummy = 2'h0;
  logic [8:0]               n_wr = 9'h000;
  logic [15:0]              n_rd = 16'h0000;
  logic                     mem_wr = 1'b0, dual = 1'b0, data_valid_o;
  logic [`SFC_ARRAY_AW-1:0] mem_waddr = '0;
  logic [7:0]               mem_wdata = 8'h00;
  logic                     cmd_ready_o, wr_ready_o, rd_valid_o, busy_o, cmd_valid_o, seq_mode_o;
  logic [7:0]               rd_data_o, cmd_opcode_o, data_o;
  logic [`SFC_ARRAY_AW-1:0] cmd_addr_o;
  logic [8:0]               cmd_count_o;
  int                       miscompares = 0, num_checks = 0, ncmd = 0, cycles = 0, ndat = 0;

  sfc_spi_if spi_if ();
  sfc_host_end sfc_host_end_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .spi(spi_if.host),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_opcode_i(cmd_opcode_i),
    .cmd_addr_i(cmd_addr_i), .cmd_n_addr_i(n_addr), .cmd_n_dummy_i(n_dummy),
    .cmd_n_wr_i(n_wr), .cmd_n_rd_i(n_rd), .cmd_dual_i(dual), .wr_valid_i(wr_valid_i),
    .wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i), .rd_valid_o(rd_valid_o),
    .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .busy_o(busy_o));
  sfc_dev_end sfc_dev_end_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .spi(spi_if.dev),
    .mem_wr_i(mem_wr), .mem_waddr_i(mem_waddr), .mem_wdata_i(mem_wdata), .aux_byte_i(aux),
    .cmd_valid_o(cmd_valid_o), .cmd_opcode_o(cmd_opcode_o), .cmd_addr_o(cmd_addr_o),
    .cmd_count_o(cmd_count_o), .data_valid_o(data_valid_o), .data_o(data_o),
    .seq_mode_o(seq_mode_o));
  sfc_link_assertions sfc_link_assertions_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .cs_n(spi_if.cs_n), .sck(spi_if.sck), .si(spi_if.si), .so(spi_if.so),
    .si_h_oe(spi_if.si_h_oe), .si_d_oe(spi_if.si_d_oe), .so_d_oe(spi_if.so_d_oe));

  always #12.5 core_clk_i = ~core_clk_i;

  // Frame pulses are one cycle long, so they are counted rather than polled
  always @(posedge core_clk_i) if (cmd_valid_o === 1'b1) ncmd <= ncmd + 1;
  always @(posedge core_clk_i) if (data_valid_o === 1'b1) ndat <= ndat + 1;

  task automatic end_sim;
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard: the whole sequence needs roughly 22000 cycles
  always @(posedge core_clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 80000)
    begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic pre(input logic [`SFC_ARRAY_AW-1:0] a, input logic [7:0] d);
    @(posedge core_clk_i) #1 mem_wr = 1'b1;
    mem_waddr = a;
    mem_wdata = d;
    @(posedge core_clk_i) #1 mem_wr = 1'b0;
  endtask

  // One whole frame: command, optional write byte, up to two read bytes
  task automatic xfer(input logic [7:0] op, input logic [23:0] ad, input logic [1:0] na,
    input logic [1:0] nd, input logic [8:0] nw, input logic [7:0] wd, input logic [15:0] nr,
    input logic [7:0] e0, input logic [7:0] e1, input int ec);
    int n0, i;
    logic [7:0] got;
    n0 = ncmd;
    @(posedge core_clk_i) #1 cmd_valid_i = 1'b1;
    {cmd_opcode_i, cmd_addr_i, n_addr, n_dummy, n_wr, n_rd} = {op, ad, na, nd, nw, nr};
    chk(cmd_ready_o, 1'b1);
    @(posedge core_clk_i) #1 cmd_valid_i = 1'b0;
    if (nw != 9'h000)
    begin
      {wr_valid_i, wr_data_i} = {1'b1, wd};
      while (wr_ready_o !== 1'b1) @(posedge core_clk_i) #1;
      @(posedge core_clk_i) #1 wr_valid_i = 1'b0;
    end
    for (i = 0; i < nr; i++)
    begin
      // An edge with ready low always passes between two pops
      do @(posedge core_clk_i) #1; while (rd_valid_o !== 1'b1);
      {got, rd_ready_i} = {rd_data_o, 1'b1};
      @(posedge core_clk_i) #1 rd_ready_i = 1'b0;
      chk(got, (i == 0) ? e0 : e1);
    end
    while (busy_o !== 1'b0) @(posedge core_clk_i) #1;
    repeat (12) @(posedge core_clk_i);
    chk(ncmd - n0, ec);
    if (ec != 0) chk(cmd_opcode_o, op);
  endtask

  task automatic t_read;
    xfer(8'h0b, 24'hf7ffff, 2'h3, 2'h1, 9'h0, 8'h00, 16'h2, 8'ha5, 8'h3c, 1);
    xfer(8'h03, 24'h07fffe, 2'h3, 2'h0, 9'h0, 8'h00, 16'h2, 8'h5a, 8'ha5, 1);
    xfer(8'h05, 24'h0, 2'h0, 2'h0, 9'h0, 8'h00, 16'h1, 8'h4e, 8'h00, 1);
    #1 dual = 1'b1;
    xfer(8'h3b, 24'h07ffff, 2'h3, 2'h1, 9'h0, 8'h00, 16'h2, 8'ha5, 8'h3c, 1);
    #1 dual = 1'b0;
  endtask

  task automatic t_prog;
    xfer(8'h02, 24'hf12345, 2'h3, 2'h0, 9'h1, 8'h96, 16'h0, 8'h00, 8'h00, 1);
    chk(data_o, 8'h96);
    chk(ndat, 1);
    chk(cmd_addr_o, 19'h12345);
    chk(cmd_count_o, 9'h001);
  endtask

  task automatic t_table;
    logic [7:0] ops [13] = '{8'h06, 8'h04, 8'hb9, 8'hab, 8'h79, 8'h60, 8'hc7,
                             8'h81, 8'h20, 8'h52, 8'hd8, 8'h36, 8'h39};
    for (int i = 0; i < 13; i++)
    begin
      xfer(ops[i], 24'h001000, (i < 7) ? 2'h0 : 2'h3, 2'h0, 9'h0, 8'h00, 16'h0, 8'h0, 8'h0, 1);
      chk(cmd_count_o, 9'h000);
    end
    xfer(8'h25, 24'h0, 2'h0, 2'h1, 9'h0, 8'h00, 16'h0, 8'h00, 8'h00, 1);
    xfer(8'h31, 24'h0, 2'h0, 2'h0, 9'h1, 8'h55, 16'h0, 8'h00, 8'h00, 1);
  endtask

  task automatic t_bad;
    xfer(8'hff, 24'h0, 2'h3, 2'h0, 9'h1, 8'h0b, 16'h0, 8'h00, 8'h00, 0);
    xfer(8'h02, 24'h0, 2'h1, 2'h0, 9'h0, 8'h00, 16'h0, 8'h00, 8'h00, 0);
    xfer(8'hf0, 24'h0, 2'h0, 2'h0, 9'h1, 8'h12, 16'h0, 8'h00, 8'h00, 0);
    xfer(8'hf0, 24'h0, 2'h0, 2'h0, 9'h1, 8'hd0, 16'h0, 8'h00, 8'h00, 1);
  endtask

  task automatic t_seq;
    xfer(8'had, 24'h000100, 2'h3, 2'h0, 9'h1, 8'h11, 16'h0, 8'h00, 8'h00, 1);
    chk(seq_mode_o, 1'b1);
    xfer(8'haf, 24'h0, 2'h0, 2'h0, 9'h1, 8'h22, 16'h0, 8'h00, 8'h00, 1);
    chk(cmd_addr_o, 19'h00101);
    xfer(8'h06, 24'h0, 2'h0, 2'h0, 9'h0, 8'h00, 16'h0, 8'h00, 8'h00, 1);
    chk(seq_mode_o, 1'b0);
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    pre(19'h7ffff, 8'ha5);
    pre(19'h00000, 8'h3c);
    pre(19'h7fffe, 8'h5a);
    t_read;
    t_prog;
    t_table;
    t_bad;
    t_seq;
    end_sim;
  end
endmodule
`default_nettype wire
